// ===== rtl/pll_clock_defs.svh
`ifndef PLL_CLOCK_DEFS_SVH
`define PLL_CLOCK_DEFS_SVH

// =====================================================
// register word indices on the plain port
`define REG_PRESCALE 4'h0
`define REG_MULT 4'h1
`define REG_GLB0 4'h2
`define REG_GLB1 4'h3
`define REG_EXT 4'h4
`define REG_FBCFG 4'h5
`define REG_STATUS 4'h6

// =====================================================
// post-scale register fields
`define PS_HIGH 5:0
`define PS_LOW 13:8
`define PS_INIT 21:16
`define PS_TAP 26:24

// =====================================================
// feedback configuration fields
`define FB_MODE 1:0
`define FB_TAP 6:4
`define FB_SEL 8
`define FB_EXT_EN 12
`define FB_EXT_DIFF 13

// =====================================================
// legal ranges and reset values
`define DIV_MIN 6'h01
`define DIV_MAX 6'h20
`define MULT_MIN 6'h02
`define N_RST 6'h01
`define M_RST 6'h08
`define HL_RST 6'h04
`define INIT_RST 6'h00
`define TAP_RST 3'h0

// =====================================================
// loop model constants
`define TAP_STEP 3'h1
`define COMP_EXT_TAPS 3'h2
`define COMP_GLB_TAPS 3'h1
`define LOCK_CNT 4'h4
`define GOOD_MAX 4'hf

`endif

// ===== rtl/pll_clock_pkg.sv
package pll_clock_pkg;

  typedef enum logic [1:0] {FB_NORMAL, FB_ZERO_DELAY, FB_NO_COMP} fb_mode_t;

  typedef enum logic [1:0] {ACQ_OFF, ACQ_WAIT_REF, ACQ_RUN} acq_state_t;

endpackage

// ===== rtl/pll_clock_synthesis_control.sv
`timescale 1ns/1ns
`include "pll_clock_defs.svh"

// Function
// [RULE1] vco runs at reference times m over n
// [RULE2] every output has its own post-scale counter off the vco
// [RULE3] software picks a common vco rate; each divider derives its output
// [RULE4] one prescale divider n, legal 1 to 32
// [RULE5] one feedback multiplier m, legal 2 to 32
// [RULE6] two global and one external post-scale divider, each 1 to 32
// [RULE7] one external output, differential or single; unused pins become general io
// [RULE8] zero-delay mode aligns external output with reference
// [RULE9] normal mode compensates one chosen internal output
// [RULE10] no-compensation mode applies no delay compensation
// [RULE11] finest phase step is one eighth of the vco period
// [RULE12] each counter picks one of eight taps plus initial count
// [RULE13] feedback tap shifts every output by the same phase
// [RULE14] lock shows stable in-phase outputs; may toggle while acquiring
// [RULE15] user logic should filter lock before using it as control
// [RULE16] each post-scale counter has separate high and low counts
// [RULE17] run enable low holds outputs at zero and drops lock
// [RULE18] run enable high again relocks and resynchronizes
// [RULE19] counter reset high clears counters, outputs and lock
// [RULE20] counter reset released resynchronizes while reacquiring lock
// [RULE21] detector gated off: vco holds setting and keeps running
// [RULE22] user logic drives detector gate from own or gated lock signal
// [RULE23] every output shiftable in 45 degree steps, one vco eighth
// [RULE24] count high and low in vco cycles; lock low while held

module pll_clock_synthesis_control (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // loop controls
  input wire logic ref_in_i,
  input wire logic run_enable_i,
  input wire logic counter_reset_i,
  input wire logic phase_frequency_detector_enable_i,
  output logic lock_o,
  output pll_clock_pkg::acq_state_t acq_state_o,
  // clock outputs
  output logic global_post_divider_first_o,
  output logic global_post_divider_second_o,
  // external clock pins
  output logic external_clock_output_p_o,
  output logic external_clock_output_p_oe_o,
  output logic external_clock_output_n_o,
  output logic external_clock_output_n_oe_o,
  input wire logic gpio_p_i,
  input wire logic gpio_p_oe_i,
  input wire logic gpio_n_i,
  input wire logic gpio_n_oe_i
);

  import pll_clock_pkg::*;

  // =====================================================
  // reset release
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // =====================================================
  // configuration registers; index 0, 1 are globals, 2 external
  logic [5:0] n_q;
  logic [5:0] m_q;
  logic [5:0] hi_q [3];
  logic [5:0] lo_q [3];
  logic [5:0] init_q [3];
  logic [2:0] tap_sel_q [3];
  fb_mode_t fb_mode_q;
  logic [2:0] fb_tap_q;
  logic comp_sel_q;
  logic ext_en_q;
  logic ext_diff_q;
  logic post_hit;
  logic [1:0] post_idx;
  logic hl_ok;

  always_comb begin
    post_hit = 1'b1;
    post_idx = 2'h0;
    case (addr_i)
      `REG_GLB0: post_idx = 2'h0;
      `REG_GLB1: post_idx = 2'h1;
      `REG_EXT: post_idx = 2'h2;
      default: post_hit = 1'b0;
    endcase
  end

  assign hl_ok = wdata_i[`PS_HIGH] >= `DIV_MIN && wdata_i[`PS_HIGH] <= `DIV_MAX &&
                 wdata_i[`PS_LOW] >= `DIV_MIN && wdata_i[`PS_LOW] <= `DIV_MAX &&
                 wdata_i[`PS_INIT] <= `DIV_MAX;

  // out-of-range divider writes are dropped so the loop never sees 0
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      n_q <= `N_RST;
      m_q <= `M_RST;
      for (int i = 0; i < 3; i++) begin
        hi_q[i] <= `HL_RST;
        lo_q[i] <= `HL_RST;
        init_q[i] <= `INIT_RST;
        tap_sel_q[i] <= `TAP_RST;
      end
      fb_mode_q <= FB_NORMAL;
      fb_tap_q <= `TAP_RST;
      comp_sel_q <= 1'b0;
      ext_en_q <= 1'b0;
      ext_diff_q <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == `REG_PRESCALE && wdata_i[5:0] >= `DIV_MIN &&
          wdata_i[5:0] <= `DIV_MAX) begin
        n_q <= wdata_i[5:0]; // RULE4
      end
      if (addr_i == `REG_MULT && wdata_i[5:0] >= `MULT_MIN &&
          wdata_i[5:0] <= `DIV_MAX) begin
        m_q <= wdata_i[5:0]; // RULE5
      end
      if (post_hit && hl_ok) begin
        hi_q[post_idx] <= wdata_i[`PS_HIGH]; // RULE6 RULE16
        lo_q[post_idx] <= wdata_i[`PS_LOW];
        init_q[post_idx] <= wdata_i[`PS_INIT];
        tap_sel_q[post_idx] <= wdata_i[`PS_TAP];
      end
      if (addr_i == `REG_FBCFG) begin
        fb_mode_q <= fb_mode_t'(wdata_i[`FB_MODE]);
        fb_tap_q <= wdata_i[`FB_TAP];
        comp_sel_q <= wdata_i[`FB_SEL];
        ext_en_q <= wdata_i[`FB_EXT_EN];
        ext_diff_q <= wdata_i[`FB_EXT_DIFF];
      end
    end
  end

  // =====================================================
  // loop state
  acq_state_t st_q;
  logic hold;
  logic ref_q;
  logic ref_rise;
  logic [5:0] ncnt_q;
  logic det_tick;
  logic [2:0] tap_q;
  logic [5:0] mcnt_q;
  logic [2:0] aligned_tap;
  logic [2:0] fb_eff;
  logic fb_tick;
  logic fb_edge;
  logic mismatch;
  logic resync;
  logic [3:0] good_q;
  logic lock_q;
  logic [2:0] post_clk;

  assign hold = !run_enable_i || counter_reset_i; // RULE17 RULE19
  assign ref_rise = ref_in_i && !ref_q;
  assign det_tick = ref_rise && (ncnt_q == n_q - `DIV_MIN); // RULE1

  // the aligned output's own tap goes into the feedback path
  always_comb begin
    unique case (fb_mode_q)
      FB_ZERO_DELAY: aligned_tap = `COMP_EXT_TAPS + tap_sel_q[2]; // RULE8
      FB_NORMAL: aligned_tap = `COMP_GLB_TAPS + tap_sel_q[comp_sel_q]; // RULE9
      FB_NO_COMP: aligned_tap = 3'h0; // RULE10
      default: aligned_tap = 3'h0;
    endcase
  end

  assign fb_eff = fb_tap_q + aligned_tap; // RULE13
  assign fb_tick = st_q == ACQ_RUN && tap_q == fb_eff;
  assign fb_edge = fb_tick && mcnt_q == 6'h00;
  assign mismatch = st_q == ACQ_RUN && det_tick && !fb_edge;
  // with the detector gated the vco free-runs in ACQ_RUN: no phase correction; the first det_tick in ACQ_WAIT_REF still resyncs
  assign resync = (st_q == ACQ_WAIT_REF && det_tick) ||
                  (mismatch && phase_frequency_detector_enable_i); // RULE21 RULE22

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ACQ_OFF;
    end else if (hold) begin
      st_q <= ACQ_OFF; // RULE17 RULE19
    end else begin
      unique case (st_q)
        ACQ_OFF: st_q <= ACQ_WAIT_REF; // RULE18 RULE20
        ACQ_WAIT_REF: if (det_tick) st_q <= ACQ_RUN;
        ACQ_RUN: st_q <= ACQ_RUN;
      endcase
    end
  end

  // prescaler counts reference rising edges
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ref_q <= 1'b0;
      ncnt_q <= 6'h00;
    end else begin
      ref_q <= ref_in_i;
      if (hold) begin
        ncnt_q <= 6'h00;
      end else if (ref_rise) begin
        ncnt_q <= det_tick ? 6'h00 : ncnt_q + 6'h01; // RULE1
      end
    end
  end

  // one clock per tap: the vco period is eight clocks
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tap_q <= 3'h0;
    end else if (hold) begin
      tap_q <= 3'h0;
    end else if (resync) begin
      tap_q <= fb_eff + `TAP_STEP;
    end else if (st_q == ACQ_RUN) begin
      tap_q <= tap_q + `TAP_STEP; // RULE11 RULE23
    end
  end

  // feedback multiplier counts vco cycles on the feedback tap
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mcnt_q <= 6'h00;
    end else if (hold) begin
      mcnt_q <= 6'h00;
    end else if (resync) begin
      mcnt_q <= 6'h01;
    end else if (fb_tick) begin
      mcnt_q <= (mcnt_q == m_q - `DIV_MIN) ? 6'h00 : mcnt_q + 6'h01; // RULE1 RULE5
    end
  end

  // lock may toggle while acquiring; filtering is left to user logic
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      good_q <= 4'h0;
      lock_q <= 1'b0;
    end else if (hold) begin
      good_q <= 4'h0;
      lock_q <= 1'b0; // RULE17 RULE19 RULE24
    end else begin
      if (mismatch) begin
        good_q <= 4'h0;
      end else if (det_tick && fb_edge && good_q != `GOOD_MAX) begin
        good_q <= good_q + 4'h1;
      end
      lock_q <= st_q == ACQ_RUN && good_q >= `LOCK_CNT; // RULE14
    end
  end

  // =====================================================
  // post-scale counters, each on its own tap
  for (genvar g = 0; g < 3; g++) begin : g_post
    post_scale_counter u_post (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .run_i(!hold && st_q == ACQ_RUN), // RULE17
      .sync_i(resync), // RULE18 RULE20
      .tick_i(!resync && st_q == ACQ_RUN && tap_q == tap_sel_q[g]), // RULE2 RULE12
      .high_i(hi_q[g]), // RULE16 RULE24
      .low_i(lo_q[g]),
      .init_i(init_q[g]),
      .clk_o(post_clk[g])
    );
  end

  // vco rate is common; each divider derives its own output from it
  assign global_post_divider_first_o = post_clk[0]; // RULE3
  assign global_post_divider_second_o = post_clk[1];
  assign lock_o = lock_q;
  assign acq_state_o = st_q;

  // =====================================================
  // external pins fall back to general io when unused
  always_comb begin
    external_clock_output_p_o = gpio_p_i;
    external_clock_output_p_oe_o = gpio_p_oe_i;
    external_clock_output_n_o = gpio_n_i;
    external_clock_output_n_oe_o = gpio_n_oe_i;
    if (ext_en_q) begin
      external_clock_output_p_o = post_clk[2]; // RULE7
      external_clock_output_p_oe_o = 1'b1;
      if (ext_diff_q) begin
        // complement only while running so a held output reads zero
        external_clock_output_n_o = !post_clk[2] && st_q == ACQ_RUN;
        external_clock_output_n_oe_o = 1'b1;
      end
    end
  end

  // =====================================================
  // register read-back, valid only in the cycle after the strobe
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (post_hit) begin
      rd_word = {5'h00, tap_sel_q[post_idx], 2'h0, init_q[post_idx], 2'h0,
                 lo_q[post_idx], 2'h0, hi_q[post_idx]};
    end
    case (addr_i)
      `REG_PRESCALE: rd_word = {26'h0, n_q};
      `REG_MULT: rd_word = {26'h0, m_q};
      `REG_FBCFG: rd_word = {18'h0, ext_diff_q, ext_en_q, 3'h0, comp_sel_q, 1'b0,
                             fb_tap_q, 2'h0, fb_mode_q};
      `REG_STATUS: rd_word = {24'h0, good_q, lock_q, 1'b0, st_q};
      default: ;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rd_i ? rd_word : 32'h0000_0000;
    end
  end

  // =====================================================
  // checks
  logic [8:0] gap_q;
  logic gap_ok_q;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 9'h000;
      gap_ok_q <= 1'b0;
    end else if (hold || wr_i) begin
      gap_q <= 9'h000;
      gap_ok_q <= 1'b0;
    end else if (resync || fb_edge) begin
      gap_q <= 9'h000;
      gap_ok_q <= st_q == ACQ_RUN || resync;
    end else begin
      gap_q <= gap_q + 9'h001;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_held;
    hold ##1 st_q == ACQ_OFF;
  endsequence

  sequence s_reacquire;
    st_q == ACQ_WAIT_REF ##0 !lock_o;
  endsequence

  property p_hold_drops_lock;
    hold |=> !lock_o;
  endproperty
  a_hold_drops_lock: assert property (p_hold_drops_lock) // RULE17
    else $error("lock high while held");

  property p_hold_clears_outputs;
    hold |=> !global_post_divider_first_o && !global_post_divider_second_o;
  endproperty
  a_hold_clears_outputs: assert property (p_hold_clears_outputs) // RULE17
    else $error("global outputs not cleared while held");

  property p_counter_reset;
    counter_reset_i |-> s_held;
  endproperty
  a_counter_reset: assert property (p_counter_reset) // RULE19
    else $error("counter reset did not stop the loop");

  property p_release_resync;
    $past(hold) && !hold |-> ##1 s_reacquire;
  endproperty
  a_release_resync: assert property (p_release_resync) // RULE20
    else $error("no reacquire after release");

  property p_fb_period;
    fb_edge && !resync && gap_ok_q && !wr_i |-> gap_q == {m_q, 3'h0} - 9'h001;
  endproperty
  a_fb_period: assert property (p_fb_period) // RULE1
    else $error("feedback edge spacing not eight times m");

  property p_tap_step;
    st_q == ACQ_RUN && !resync && !hold |=> tap_q == $past(tap_q) + `TAP_STEP;
  endproperty
  a_tap_step: assert property (p_tap_step) // RULE11
    else $error("tap did not advance by one");

  property p_gate_holds;
    !phase_frequency_detector_enable_i && st_q == ACQ_RUN |-> !resync;
  endproperty
  a_gate_holds: assert property (p_gate_holds) // RULE21
    else $error("loop corrected while detector gated");

  property p_mismatch_unlocks;
    mismatch && !hold ##1 !hold |=> !lock_o;
  endproperty
  a_mismatch_unlocks: assert property (p_mismatch_unlocks) // RULE14
    else $error("lock held across phase mismatch");

  property p_div_range;
    n_q >= `DIV_MIN && n_q <= `DIV_MAX && m_q >= `MULT_MIN && m_q <= `DIV_MAX;
  endproperty
  a_div_range: assert property (p_div_range) // RULE4
    else $error("divider out of range");

endmodule

// ===== rtl/post_scale_counter.sv
`timescale 1ns/1ns
`include "pll_clock_defs.svh"

module post_scale_counter (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  input wire logic sync_i,
  input wire logic tick_i,
  // settings
  input wire logic [5:0] high_i,
  input wire logic [5:0] low_i,
  input wire logic [5:0] init_i,
  // output
  output logic clk_o
);

  logic [5:0] cnt_q;
  logic started_q;

  // =====================================================
  // counting in vco cycles of the selected tap
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 6'h00;
      started_q <= 1'b0;
      clk_o <= 1'b0;
    end else if (!run_i || sync_i) begin
      // initial count delays the first high phase
      cnt_q <= init_i;
      started_q <= 1'b0;
      clk_o <= 1'b0;
    end else if (tick_i) begin
      if (!started_q) begin
        if (cnt_q == 6'h00) begin
          started_q <= 1'b1;
          clk_o <= 1'b1;
          cnt_q <= high_i - `DIV_MIN;
        end else begin
          cnt_q <= cnt_q - 6'h01;
        end
      end else if (cnt_q == 6'h00) begin
        clk_o <= !clk_o;
        cnt_q <= (clk_o ? low_i : high_i) - `DIV_MIN;
      end else begin
        cnt_q <= cnt_q - 6'h01;
      end
    end
  end

endmodule

// ===== verif/pll_clock_synthesis_control_tb.sv
`timescale 1ns/1ns
`include "pll_clock_defs.svh"

module pll_clock_synthesis_control_tb;
  import pll_clock_pkg::*;

  localparam int VCO_CLKS = 8;
  logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, lfsr_q = 32'hc93f;
  logic ref_run = 1'b1, run_en = 1'b1, crst = 1'b1, gate_req = 1'b1;
  logic gp = 1'b0, gpoe = 1'b0, gn = 1'b0, gnoe = 1'b0;
  logic [31:0] rdata;
  logic lock, glb_first, glb_second, ep, epoe, en, enoe, ref_in, gate_en, lock_filt;
  acq_state_t acq;
  logic [31:0] mreg [16];
  int failures = 0, n_checks = 0;
  int wa [12] = '{0, 0, 0, 1, 1, 2, 2, 3, 4, 5, 6, 9};
  logic [31:0] wd [12] = '{32'h0, 32'h21, 32'h20, 32'h1, 32'h14, 32'h0300, 32'h05200203,
    32'h2101, 32'h07000101, 32'h3173, 32'hff, 32'h1};
  int hi, lo, h1, l1, k;

  always #25 clk = ~clk;

  pll_clock_synthesis_control DUT (
    .ref_clk_i(clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .ref_in_i(ref_in), .run_enable_i(run_en),
    .counter_reset_i(crst), .phase_frequency_detector_enable_i(gate_en), .lock_o(lock),
    .acq_state_o(acq), .global_post_divider_first_o(glb_first),
    .global_post_divider_second_o(glb_second),
    .external_clock_output_p_o(ep), .external_clock_output_p_oe_o(epoe),
    .external_clock_output_n_o(en), .external_clock_output_n_oe_o(enoe), .gpio_p_i(gp),
    .gpio_p_oe_i(gpoe), .gpio_n_i(gn), .gpio_n_oe_i(gnoe));

  user_fabric_model #(.REF_HALF(8)) fabric (
    .clk_i(clk), .rst_n_i(resetn), .ref_run_i(ref_run), .ref_o(ref_in), .lock_i(lock),
    .lock_filt_o(lock_filt), .gate_req_i(gate_req), .gate_en_o(gate_en));

  // =====================================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] model_wr(input int a, input logic [31:0] d);
    case (a)
      0: return (d[5:0] >= 1 && d[5:0] <= 32) ? (d & 32'h3f) : mreg[0];
      1: return (d[5:0] >= 2 && d[5:0] <= 32) ? (d & 32'h3f) : mreg[1];
      2, 3, 4: return (d[5:0] >= 1 && d[5:0] <= 32 && d[13:8] >= 1 && d[13:8] <= 32 &&
        d[21:16] <= 32) ? (d & 32'h073f3f3f) : mreg[a];
      5: return d & 32'h3173;
      default: return mreg[a];
    endcase
  endfunction

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input int a, input logic [31:0] d);
    step();
    addr <= a[3:0];
    wdata <= d;
    wr <= 1'b1;
    step();
    wr <= 1'b0;
    mreg[a] = model_wr(a, d);
  endtask

  task automatic rd_check(input int a);
    step();
    addr <= a[3:0];
    rd <= 1'b1;
    step();
    rd <= 1'b0;
    check("rdata", mreg[a], rdata);
    step();
    check("rdata idle", 32'h0, rdata);
  endtask

  task automatic wait_lock(input string what);
    // a pending mismatch needs up to one reference period to drop lock
    repeat (24) step();
    for (k = 0; k < 600 && lock !== 1'b1; k++) step();
    check(what, 32'h1, {31'h0, lock});
  endtask

  function automatic logic glb(input int s);
    return s ? glb_second : glb_first;
  endfunction

  task automatic measure(input int s, output int h, output int l);
    h = 0;
    l = 0;
    for (k = 0; k < 400 && glb(s) !== 1'b0; k++) step();
    for (k = 0; k < 400 && glb(s) !== 1'b1; k++) step();
    while (glb(s) === 1'b1 && h < 400) begin
      h++;
      step();
    end
    while (glb(s) === 1'b0 && l < 400) begin
      l++;
      step();
    end
  endtask

  task automatic hold(input int which);
    logic [4:0] acc;
    acc = 5'h0;
    if (which) crst <= 1'b1;
    else run_en <= 1'b0;
    repeat (2) step();
    for (k = 0; k < 40; k++) begin
      acc = acc | {lock, glb_first, glb_second, acq};
      step();
    end
    check("held outputs", 32'h0, {27'h0, acc});
    crst <= 1'b0;
    run_en <= 1'b1;
    wait_lock("relock");
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // =====================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end

  // =====================================================
  // main sequence
  initial begin
    foreach (mreg[i]) mreg[i] = 32'h0;
    mreg[0] = 32'h1;
    mreg[1] = 32'h8;
    for (k = 2; k < 5; k++) mreg[k] = 32'h0404;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 7; i++) rd_check(i);
    for (int i = 0; i < 12; i++) wr_reg(wa[i], wd[i]);
    lfsr_q = lfsr_next(lfsr_q);
    wr_reg(`REG_MULT, 32'd2 + (lfsr_q % 31));
    for (int i = 0; i < 16; i++) rd_check(i);
    $display("test registers done");
    lfsr_q = lfsr_next(lfsr_q);
    h1 = 1 + lfsr_q[1:0];
    l1 = 1 + lfsr_q[3:2];
    wr_reg(`REG_PRESCALE, 32'h1);
    wr_reg(`REG_MULT, 32'h2);
    wr_reg(`REG_GLB0, 32'h0302);
    wr_reg(`REG_GLB1, (l1 << 8) | h1);
    wr_reg(`REG_FBCFG, 32'h0);
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      {gp, gpoe, gn, gnoe} <= lfsr_q[3:0];
      step();
      check("gpio pins", {28'h0, lfsr_q[3:0]}, {28'h0, ep, epoe, en, enoe});
    end
    $display("test gpio done");
    crst <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      wr_reg(`REG_FBCFG, m);
      wait_lock("lock per mode");
    end
    measure(0, hi, lo);
    check("first high", 2 * VCO_CLKS, hi);
    check("first low", 3 * VCO_CLKS, lo);
    measure(1, hi, lo);
    check("second high", h1 * VCO_CLKS, hi);
    check("second low", l1 * VCO_CLKS, lo);
    check("filtered lock", 32'h1, {31'h0, lock_filt});
    wr_reg(`REG_FBCFG, 32'h3002);
    hi = 0;
    for (int i = 0; i < 32; i++) begin
      step();
      check("ext pair", 32'h3, {30'h0, epoe & enoe, ep ^ en});
      hi = hi + ep;
    end
    check("ext toggles", 32'h1, {31'h0, hi > 0});
    $display("test lock and duty done");
    hold(0);
    hold(1);
    $display("test hold done");
    gate_req <= 1'b0;
    ref_run <= 1'b0;
    hi = 0;
    lo = 1;
    for (int i = 0; i < 160; i++) begin
      step();
      if (glb_first === 1'b1 && lo == 0) hi++;
      lo = (glb_first === 1'b1) ? 1 : 0;
    end
    check("free running", 32'h1, {31'h0, hi > 2});
    check("gated state", {30'h0, ACQ_RUN}, {30'h0, acq});
    $display("test gated detector done");
    end_of_test();
  end
endmodule

// ===== verif/user_fabric_model.sv
`timescale 1ns/1ns

module user_fabric_model #(
  parameter int REF_HALF = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // reference source
  input wire logic ref_run_i,
  output logic ref_o,
  // lock handling
  input wire logic lock_i,
  output logic lock_filt_o,
  // detector gate
  input wire logic gate_req_i,
  output logic gate_en_o
);
  int half_q;
  int stable_q;

  // =====================================================
  // reference clock; stands still at its last level when stopped
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half_q <= 0;
      ref_o <= 1'b0;
    end else if (ref_run_i) begin
      if (half_q == REF_HALF - 1) begin
        half_q <= 0;
        ref_o <= ~ref_o;
      end else begin
        half_q <= half_q + 1;
      end
    end
  end

  // =====================================================
  // lock is only trusted after 8 quiet cycles, so lock pulses shorter than 8 cycles never reach users
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stable_q <= 0;
    end else if (!lock_i) begin
      stable_q <= 0;
    end else if (stable_q < 8) begin
      stable_q <= stable_q + 1;
    end
  end

  assign lock_filt_o = (stable_q >= 8);
  assign gate_en_o = gate_req_i;
endmodule
